// file: logic/phase_table.sv
`timescale 1ns/10ps
`default_nettype none
// Sixteen loaded values mirrored to both phases over 64 step angles
module phase_table #(
    parameter int VALUE_BITS = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Load port
    input wire logic load,
    input wire logic [3:0] load_index,
    input wire logic [VALUE_BITS-1:0] load_value,
    // Lookup
    input wire logic [5:0] angle,
    output logic [VALUE_BITS-1:0] level_a,
    output logic [VALUE_BITS-1:0] level_b
);
    logic [VALUE_BITS-1:0] entry_q [16];
    logic [3:0] idx;
    logic zero_a;
    logic zero_b;
    logic [3:0] idx_a;
    logic [3:0] idx_b;

    // Only 16 values are kept; entries 0..14 each stand for eight table places, entry 15 for four
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) begin
                entry_q[i] <= '0;
            end
        end else if (load) begin
            entry_q[load_index] <= load_value;
        end
    end

    // Quadrant folding of the step angle onto a table index
    always_comb begin
        idx = angle[3:0];
        zero_a = 1'b0;
        zero_b = 1'b0;
        idx_a = 4'h0;
        idx_b = 4'h0;
        if (angle[4] == 1'b0) begin
            zero_a = (idx == 4'h0);
            idx_a = idx - 4'h1;
            idx_b = 4'hf - idx;
        end else begin
            zero_b = (idx == 4'h0);
            idx_a = 4'hf - idx;
            idx_b = idx - 4'h1;
        end
        level_a = zero_a ? '0 : entry_q[idx_a];
        level_b = zero_b ? '0 : entry_q[idx_b];
    end
endmodule : phase_table
`default_nettype wire

// file: logic/stepper_regs_pkg.sv
// How it works
// - Two-bit delay code picks how long a short persists before it is flagged.
// - Four-bit PWM count gap sets stall threshold, reset value eight.
// - Two-bit select drives monitor pin: fault low, stall low, phase A PWM, temperature.
// - Bridges enabled when register enable bit or enable pin is high.
// - Two-bit open-load limit: 20, 30 default, 40 or 50 percent.
// - Recirculation side bit, high side default; separate brake bit, off by default.
// - Slew limiting bit, reset value one so limiting starts enabled.
// - Two-bit decay select: slow, mixed fixed default, mixed auto, fast.
// - Signed six-bit step delta written to run register adds to step angle.
// - Top bits both one select table load; bits 5..0 value, bit 6 odd parity.
// - Values 0..14 fill eight mirrored places each, value 15 four; angles 0,32 (A) and 16,48 (B) stay zero.
// - First fault word: summary, thermal code, supply high, low, stall, open loads.
// - Low byte of first fault word holds the eight bridge switch short flags.
// - Second fault word: upper byte copied, bits 7..6 zero, step angle below.
// - Thermal code: none, cold warning, hot warning, overtemperature shutdown.
// - Summary flag high when any first-word flag or a transfer or parity error.
// - Fault words clear after every access; first word all ones after power-on.
// - Table loads fill entries 0..15 in order; extra ignored; break restarts pointer.
// - Parity failure still stores the value and raises the summary flag.
package stepper_regs_pkg;
    // Register select codes in bits 15..14
    localparam logic [1:0] SEL_CONFIG_A = 2'h0;
    localparam logic [1:0] SEL_CONFIG_B = 2'h1;
    localparam logic [1:0] SEL_RUN = 2'h2;
    localparam logic [1:0] SEL_TABLE = 2'h3;
    localparam int SEL_MSB = 15;
    localparam int SEL_LSB = 14;
    localparam int WORD_BITS = 16;

    // Configuration B fields
    localparam int CFGB_OSC = 13;
    localparam int CFGB_OCD_LSB = 11;
    localparam int CFGB_GAP_LSB = 2;
    localparam int CFGB_MON_LSB = 0;
    localparam logic [1:0] OCD_DELAY_RESET = 2'h2;
    localparam logic [3:0] PWM_GAP_RESET = 4'h8;
    localparam logic [1:0] MON_SEL_RESET = 2'h0;

    // Run register fields
    localparam int RUN_EN = 13;
    localparam int RUN_OL_LSB = 11;
    localparam int RUN_HLR = 10;
    localparam int RUN_SLEW = 9;
    localparam int RUN_BRK = 8;
    localparam int RUN_DCY_LSB = 6;
    localparam int RUN_SC_LSB = 0;
    localparam logic [1:0] OPEN_LOAD_RESET = 2'h1;
    localparam logic [1:0] DECAY_RESET = 2'h1;

    // Table load fields
    localparam int TBL_PARITY = 6;
    localparam int TBL_ENTRIES = 16;

    // Monitor pin sources
    localparam logic [1:0] MON_FAULT = 2'h0;
    localparam logic [1:0] MON_STALL = 2'h1;
    localparam logic [1:0] MON_PWM_A = 2'h2;
    localparam logic [1:0] MON_TEMP = 2'h3;

    // Fault word layout
    localparam int FLT_SUMMARY = 15;
    localparam int FLT_THERM_LSB = 13;
    localparam int FLT_SUPPLY_HIGH = 12;
    localparam int FLT_SUPPLY_LOW = 11;
    localparam int FLT_HALT = 10;
    localparam int FLT_OPEN_B = 9;
    localparam int FLT_OPEN_A = 8;
    localparam logic [15:0] FAULT_A_POWER_ON = 16'hffff;

    // Overcurrent detect delays, in ns, and the core clock period
    localparam int CLOCK_NS = 10;
    localparam int OCD_DELAY0_NS = 500;
    localparam int OCD_DELAY1_NS = 1000;
    localparam int OCD_DELAY2_NS = 2000;
    localparam int OCD_DELAY3_NS = 3000;
    localparam logic [8:0] OCD_CYC0 = 9'((OCD_DELAY0_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [8:0] OCD_CYC1 = 9'((OCD_DELAY1_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [8:0] OCD_CYC2 = 9'((OCD_DELAY2_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [8:0] OCD_CYC3 = 9'((OCD_DELAY3_NS + CLOCK_NS - 1) / CLOCK_NS);
endpackage : stepper_regs_pkg

// file: logic/stepper_serial_regs.sv
`timescale 1ns/10ps
`default_nettype none
module stepper_serial_regs (
    // Core clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Serial link
    input wire logic serial_clock,
    input wire logic frame_strobe_low,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Pins and raw fault sources
    input wire logic enable_pin,
    input wire logic [1:0] thermal_code_in,
    input wire logic supply_high_in,
    input wire logic supply_low_in,
    input wire logic rotor_halt_in,
    input wire logic open_load_b_in,
    input wire logic open_load_a_in,
    input wire logic [7:0] short_raw_in,
    input wire logic pwm_a_on_in,
    // Configuration to the drive logic
    output logic clock_source_ext,
    output logic [1:0] overcurrent_detect_delay,
    output logic [3:0] pwm_count_gap,
    output logic [1:0] open_load_limit,
    output logic recirc_side_select,
    output logic slew_limit_on,
    output logic brake_on,
    output logic [1:0] decay_select,
    output logic bridge_enable,
    output logic monitor_pin,
    // Step angle and phase levels
    output logic [5:0] step_angle,
    output logic [5:0] phase_a_level,
    output logic [5:0] phase_b_level
);
    // Link domain state; the link clock only runs inside frames
    logic [15:0] rx_shift_q;
    logic [7:0] link_count_q = 8'h00; // No reset reaches the link side; start from zero
    logic sdo_q;
    // Core domain state
    logic [2:0] strobe_sync_q;
    logic [2:0] enable_sync_q [2];
    logic [14:0] raw_s1_q;
    logic [14:0] raw_s2_q;
    logic pwm_s1_q;
    logic pwm_s2_q;
    logic [7:0] prev_count_q;
    logic [15:0] cfgb_q;
    logic [15:0] run_q;
    logic [5:0] angle_q;
    logic [4:0] tbl_ptr_q;
    logic err_q;
    logic [14:0] fault_a_q;
    logic sel_b_q;
    logic [15:0] tx_word_q;
    logic [7:0] short_flag;
    logic bridge_q;
    logic monitor_q;
    logic oe_q;
    logic [5:0] level_a_q;
    logic [5:0] level_b_q;
    logic [5:0] level_a;
    logic [5:0] level_b;
    // Frame decode
    logic frame_done;
    logic [7:0] frame_bits;
    logic frame_ok;
    logic [1:0] sel;
    logic parity_ok;
    logic table_load;
    logic summary;
    logic [15:0] fault_a_word;
    logic [15:0] fault_b_word;
    logic [8:0] ocd_limit;

    // Receive shift and edge count on the link clock; no reset exists here
    always_ff @(posedge serial_clock) begin
        if (!frame_strobe_low) begin
            rx_shift_q <= {rx_shift_q[14:0], serial_in};
            link_count_q <= link_count_q + 8'h01;
        end
    end

    // Transmit on falling edges; the frame's leading falling edge presents bit 15.
    // The bit index counts from the snapshot taken at the last frame end, so a short
    // frame does not shift every later reply. The word in tx_word_q is reloaded every core clock;
    // a fault that lands inside a frame may show in only part of the reply.
    always_ff @(negedge serial_clock) begin
        if (!frame_strobe_low) begin
            sdo_q <= tx_word_q[4'hf - (link_count_q[3:0] - prev_count_q[3:0])];
        end
    end

    // Strobe synchroniser plus one stage for edge detection
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            strobe_sync_q <= 3'h7;
        end else begin
            strobe_sync_q <= {strobe_sync_q[1:0], frame_strobe_low};
        end
    end

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            enable_sync_q[0] <= 3'h0;
            enable_sync_q[1] <= 3'h0;
            raw_s1_q <= 15'h0000;
            raw_s2_q <= 15'h0000;
            pwm_s1_q <= 1'b0;
            pwm_s2_q <= 1'b0;
        end else begin
            enable_sync_q[0] <= {2'h0, enable_pin};
            enable_sync_q[1] <= enable_sync_q[0];
            raw_s1_q <= {thermal_code_in, supply_high_in, supply_low_in, rotor_halt_in,
                open_load_b_in, open_load_a_in, short_raw_in};
            raw_s2_q <= raw_s1_q;
            pwm_s1_q <= pwm_a_on_in;
            pwm_s2_q <= pwm_s1_q;
        end
    end

    // A frame ends on the strobe's rising edge; link state is frozen by then
    assign frame_done = strobe_sync_q[1] & ~strobe_sync_q[2];
    assign frame_bits = link_count_q - prev_count_q;
    assign frame_ok = (frame_bits == 8'(stepper_regs_pkg::WORD_BITS));
    assign sel = rx_shift_q[stepper_regs_pkg::SEL_MSB:stepper_regs_pkg::SEL_LSB];
    assign parity_ok = ^rx_shift_q[6:0];
    assign table_load = frame_done & frame_ok & (sel == stepper_regs_pkg::SEL_TABLE)
        & (tbl_ptr_q < 5'(stepper_regs_pkg::TBL_ENTRIES));

    // Edge count snapshot between frames, used to spot short or long frames
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prev_count_q <= link_count_q; // Link count survives reset; keep frames aligned
        end else if (frame_done) begin
            prev_count_q <= link_count_q;
        end
    end

    // Configuration B and run registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cfgb_q <= {2'h1, 1'b0, stepper_regs_pkg::OCD_DELAY_RESET, 5'h00,
                stepper_regs_pkg::PWM_GAP_RESET, stepper_regs_pkg::MON_SEL_RESET};
            run_q <= {2'h2, 1'b0, stepper_regs_pkg::OPEN_LOAD_RESET, 1'b0, 1'b1, 1'b0,
                stepper_regs_pkg::DECAY_RESET, 6'h00};
        end else if (frame_done && frame_ok) begin
            if (sel == stepper_regs_pkg::SEL_CONFIG_B) begin
                cfgb_q <= rx_shift_q;
            end
            if (sel == stepper_regs_pkg::SEL_RUN) begin
                run_q <= rx_shift_q;
            end
        end
    end

    // Step angle moves by the signed delta of each run write, wrapping at 64
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            angle_q <= 6'h00;
        end else if (frame_done && frame_ok && sel == stepper_regs_pkg::SEL_RUN) begin
            angle_q <= angle_q + rx_shift_q[5:0];
        end
    end

    // Table pointer: any break in the load sequence starts it over
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tbl_ptr_q <= 5'h00;
        end else if (frame_done) begin
            if (!frame_ok || sel != stepper_regs_pkg::SEL_TABLE) begin
                tbl_ptr_q <= 5'h00;
            end else if (table_load) begin
                tbl_ptr_q <= tbl_ptr_q + 5'h01;
            end
        end
    end

    // Transfer and parity errors; the set of this frame wins over its clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            err_q <= 1'b0;
        end else if (frame_done) begin
            err_q <= !frame_ok || (sel == stepper_regs_pkg::SEL_TABLE && !parity_ok);
        end
    end

    // Overcurrent qualifiers: a short must persist for the selected delay
    always_comb begin
        unique case (cfgb_q[stepper_regs_pkg::CFGB_OCD_LSB +: 2])
            2'h0: ocd_limit = stepper_regs_pkg::OCD_CYC0;
            2'h1: ocd_limit = stepper_regs_pkg::OCD_CYC1;
            2'h2: ocd_limit = stepper_regs_pkg::OCD_CYC2;
            2'h3: ocd_limit = stepper_regs_pkg::OCD_CYC3;
        endcase
    end

    for (genvar g = 0; g < 8; g++) begin : g_short
        logic [8:0] persist_q;
        // Count saturates at the limit so a long short keeps its flag raised
        always_ff @(posedge clock) begin
            if (!reset_n || !raw_s2_q[g]) begin
                persist_q <= 9'h000;
            end else if (persist_q < ocd_limit) begin
                persist_q <= persist_q + 9'h001;
            end
        end
        assign short_flag[g] = raw_s2_q[g] && (persist_q >= ocd_limit);
        chk_short_delay: assert property (@(posedge clock) disable iff (!reset_n)
            $rose(short_flag[g]) |-> persist_q == ocd_limit)
            else $error("short flagged before its delay");
    end

    // First fault word: sticky, cleared by each access, new events win
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fault_a_q <= stepper_regs_pkg::FAULT_A_POWER_ON[14:0];
        end else begin
            fault_a_q[12:8] <= (frame_done ? 5'h00 : fault_a_q[12:8]) | raw_s2_q[12:8];
            fault_a_q[7:0] <= (frame_done ? 8'h00 : fault_a_q[7:0]) | short_flag;
            // Thermal code keeps the worst level seen since the last access
            if (frame_done || raw_s2_q[14:13] > fault_a_q[14:13]) begin
                fault_a_q[14:13] <= raw_s2_q[14:13];
            end
        end
    end

    assign summary = (|fault_a_q) | err_q;
    assign fault_a_word = {summary, fault_a_q};
    assign fault_b_word = {summary, fault_a_q[14:8], 2'h0, angle_q};

    // A run write makes the next frame return the second fault word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sel_b_q <= 1'b0;
        end else if (frame_done) begin
            sel_b_q <= frame_ok && sel == stepper_regs_pkg::SEL_RUN;
        end
    end

    // Word offered to the link for the next frame
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_word_q <= stepper_regs_pkg::FAULT_A_POWER_ON;
        end else begin
            tx_word_q <= sel_b_q ? fault_b_word : fault_a_word;
        end
    end

    // Bridge enable, monitor pin and output enable, all registered
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bridge_q <= 1'b0;
            monitor_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            bridge_q <= run_q[stepper_regs_pkg::RUN_EN] | enable_sync_q[1][0];
            oe_q <= ~strobe_sync_q[1];
            unique case (cfgb_q[stepper_regs_pkg::CFGB_MON_LSB +: 2])
                stepper_regs_pkg::MON_FAULT: monitor_q <= ~summary;
                stepper_regs_pkg::MON_STALL: monitor_q <= ~fault_a_q[stepper_regs_pkg::FLT_HALT];
                stepper_regs_pkg::MON_PWM_A: monitor_q <= pwm_s2_q;
                stepper_regs_pkg::MON_TEMP: monitor_q <= |fault_a_q[14:13];
            endcase
        end
    end

    phase_table #(
        .VALUE_BITS(6)
    ) u_table (
        .clock(clock),
        .reset_n(reset_n),
        .load(table_load),
        .load_index(tbl_ptr_q[3:0]),
        .load_value(rx_shift_q[5:0]),
        .angle(angle_q),
        .level_a(level_a),
        .level_b(level_b)
    );

    // Phase levels registered so that outputs come from flip-flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            level_a_q <= 6'h00;
            level_b_q <= 6'h00;
        end else begin
            level_a_q <= level_a;
            level_b_q <= level_b;
        end
    end

    assign serial_out = sdo_q;
    assign serial_out_oe = oe_q;
    assign clock_source_ext = cfgb_q[stepper_regs_pkg::CFGB_OSC];
    assign overcurrent_detect_delay = cfgb_q[stepper_regs_pkg::CFGB_OCD_LSB +: 2];
    assign pwm_count_gap = cfgb_q[stepper_regs_pkg::CFGB_GAP_LSB +: 4];
    assign open_load_limit = run_q[stepper_regs_pkg::RUN_OL_LSB +: 2];
    assign recirc_side_select = run_q[stepper_regs_pkg::RUN_HLR];
    assign slew_limit_on = run_q[stepper_regs_pkg::RUN_SLEW];
    assign brake_on = run_q[stepper_regs_pkg::RUN_BRK];
    assign decay_select = run_q[stepper_regs_pkg::RUN_DCY_LSB +: 2];
    assign bridge_enable = bridge_q;
    assign monitor_pin = monitor_q;
    assign step_angle = angle_q;
    assign phase_a_level = level_a_q;
    assign phase_b_level = level_b_q;

    chk_bridge_or: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 bridge_q == ($past(run_q[13]) | $past(enable_sync_q[1][0])))
        else $error("bridge enable is not the OR of bit and pin");
    chk_angle_delta: assert property (@(posedge clock) disable iff (!reset_n)
        frame_done && frame_ok && sel == 2'h2
        |=> angle_q == $past(angle_q) + $past(rx_shift_q[5:0]))
        else $error("step delta not applied");
    chk_ptr_bound: assert property (@(posedge clock) disable iff (!reset_n)
        tbl_ptr_q <= 5'h10)
        else $error("table pointer past sixteen");
    chk_ptr_restart: assert property (@(posedge clock) disable iff (!reset_n)
        frame_done && (!frame_ok || sel != 2'h3) |=> tbl_ptr_q == 5'h00)
        else $error("table pointer not restarted");
    chk_parity_error: assert property (@(posedge clock) disable iff (!reset_n)
        frame_done && frame_ok && sel == 2'h3 && !parity_ok |=> err_q && summary)
        else $error("parity failure not flagged");
    chk_summary_flag: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> tx_word_q[15] == ((|$past(fault_a_q)) | $past(err_q)))
        else $error("summary flag wrong");
    chk_word_b_layout: assert property (@(posedge clock) disable iff (!reset_n)
        fault_b_word[15:8] == fault_a_word[15:8] && fault_b_word[7:6] == 2'h0
        && fault_b_word[5:0] == step_angle)
        else $error("second fault word layout wrong");
    chk_monitor_fault: assert property (@(posedge clock) disable iff (!reset_n)
        cfgb_q[1:0] == 2'h0 |=> monitor_pin == !$past(summary))
        else $error("monitor pin does not show fault low");
    chk_access_clear: assert property (@(posedge clock) disable iff (!reset_n)
        frame_done && raw_s2_q[12:8] == 5'h00 |=> fault_a_q[12:8] == 5'h00)
        else $error("fault flags not cleared by access");
endmodule : stepper_serial_regs
`default_nettype wire

// file: tb/ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// Serial controller on the far side: mode 3 master, strobe framed, clock only inside frames
module ctrl_model (
    // Serial link
    output logic serial_clock,
    output logic frame_strobe_low,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // Link idles with clock high and strobe high
    initial begin
        serial_clock = 1'b1;
        frame_strobe_low = 1'b1;
        serial_in = 1'b0;
    end

    // One frame of n bits, MSB first; a slow frame stretches the low clock phase
    task automatic xfer(input logic [15:0] wd, input int n, input logic slow,
                        output logic [15:0] rd);
        rd = 16'h0000;
        frame_strobe_low = 1'b0;
        #3.3;
        for (int i = 0; i < n; i++) begin
            serial_clock = 1'b0;
            serial_in = wd[15 - i];
            #(slow ? 37.5 : 7.5);
            serial_clock = 1'b1;
            rd = {rd[14:0], serial_out};
            #7.5;
        end
        #4.1;
        frame_strobe_low = 1'b1;
        // A released line must not look like a stale copy of the last bit
        serial_in = ~serial_in;
        // Gap lets the core load the next reply; no step pulses are ever sent
        #120;
    endtask : xfer
endmodule : ctrl_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module testbench;
    // Core side
    logic clock, reset_n, enable_pin, pwm_a_on_in;
    logic supply_high_in, supply_low_in, rotor_halt_in, open_load_b_in, open_load_a_in;
    logic [1:0] thermal_code_in, overcurrent_detect_delay, open_load_limit, decay_select;
    logic [7:0] short_raw_in;
    logic [3:0] pwm_count_gap;
    logic clock_source_ext, recirc_side_select, slew_limit_on, brake_on, bridge_enable;
    logic monitor_pin, p;
    logic [5:0] step_angle, phase_a_level, phase_b_level, ang, v;
    logic [5:0] tab [16];
    // Serial link
    logic serial_clock, frame_strobe_low, serial_in, serial_out, serial_out_oe;
    logic [15:0] rd, w;
    logic [13:0] seen;
    logic [14:0] fl;
    logic oe_seen;
    int err_total = 0, tests_run = 0, cycles = 0, seed = 65516;

    stepper_serial_regs stepper_serial_regs_i (.*);
    ctrl_model ctrl_model_i (.*);

    // Output enable as the last falling link edge of each frame finds it
    always @(negedge serial_clock) oe_seen = serial_out_oe;

    // Core clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Expected phase A level: quadrant mirror, zero at 0 and 32
    function automatic logic [5:0] lvl_a(input logic [5:0] a);
        int m;
        m = a % 32;
        if (m == 0) return 6'h00;
        return (m <= 16) ? tab[m - 1] : tab[31 - m];
    endfunction : lvl_a

    // Expected phase B level: zero at 16 and 48
    function automatic logic [5:0] lvl_b(input logic [5:0] a);
        int m;
        m = a % 32;
        if (m == 16) return 6'h00;
        return (m < 16) ? tab[15 - m] : tab[m - 17];
    endfunction : lvl_b

    // One frame, prompt or slow at random, then step off the edge
    task automatic frame(input logic [15:0] wd, input int n);
        ctrl_model_i.xfer(wd, n, 1'($random(seed)), rd);
        @(posedge clock);
        #1;
    endtask : frame

    // Run write with default fields; the expected angle follows the signed delta
    task automatic run_wr(input logic [5:0] d);
        ang = ang + d;
        frame({2'b10, 8'h29, d}, 16);
    endtask : run_wr

    task automatic set_faults(input logic [14:0] f);
        {thermal_code_in, supply_high_in, supply_low_in, rotor_halt_in, open_load_b_in,
            open_load_a_in, short_raw_in} = f;
    endtask : set_faults

    initial begin
        reset_n = 1'b0;
        enable_pin = 1'b0;
        pwm_a_on_in = 1'b0;
        ang = 6'h00;
        set_faults(15'h0000);
        repeat (20) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK("delay", 2'h2, overcurrent_detect_delay)
        `CHK("gap", 4'h8, pwm_count_gap)
        `CHK("bridge", 1'b0, bridge_enable)
        `CHK("open load", 2'h1, open_load_limit)
        `CHK("recirc brake", 2'h0, {recirc_side_select, brake_on})
        `CHK("slew", 1'b1, slew_limit_on)
        `CHK("decay", 2'h1, decay_select)
        frame(16'h4200, 16);
        `CHK("power-on word", 16'hffff, rd)
        `CHK("oe in frame", 1'b1, oe_seen)
        `CHK("oe idle", 1'b0, serial_out_oe)
        frame(16'h4200, 16);
        `CHK("cleared word", 16'h0000, rd)
        $display("test defaults ended");
        // Random configuration and run writes, every monitor source, deltas of -32 and -1 first
        for (int i = 0; i < 12; i++) begin
            w = $random(seed);
            pwm_a_on_in = w[15];
            frame({2'b01, w[13:2], i[1:0]}, 16);
            `CHK("word b", (i > 0) ? {10'h000, ang} : 16'h0000, rd)
            seen[6:0] = {clock_source_ext, overcurrent_detect_delay, pwm_count_gap};
            `CHK("cfg", {w[13:11], w[5:2]}, seen[6:0])
            `CHK("monitor", (i % 4 == 2) ? pwm_a_on_in : (i % 4 != 3), monitor_pin)
            w = $random(seed);
            if (i < 2) w[5:0] = i ? 6'h3f : 6'h20;
            enable_pin = w[15];
            ang = ang + w[5:0];
            frame({2'b10, w[13:0]}, 16);
            seen = {bridge_enable, open_load_limit, recirc_side_select, slew_limit_on, brake_on,
                decay_select, step_angle};
            `CHK("run", {w[13] | w[15], w[12:6], ang}, seen)
        end
        $display("test registers ended");
        // Fault word layout over every thermal code; flags still present at an access re-arm
        fl = 15'h0000;
        frame(16'h4000, 16);
        for (int t = 0; t < 4; t++) begin
            w = $random(seed);
            set_faults({t[1:0], w[12:0]});
            fl = {t[1:0], fl[12:0] | w[12:0]};
            repeat (80) @(posedge clock);
            #1;
            run_wr(w[5:0]);
            `CHK("word a", {|fl, fl}, rd)
            fl = {t[1:0], w[12:0]};
            repeat (80) @(posedge clock);
            #1;
            frame(16'h4000, 16);
            `CHK("word b", {|fl, fl[14:8], 2'b00, ang}, rd)
        end
        set_faults(15'h0000);
        repeat (10) @(posedge clock);
        #1;
        frame(16'h4000, 16);
        frame(16'h8001, 15);
        `CHK("refused frame", ang, step_angle)
        frame(16'h4000, 16);
        `CHK("error summary", 16'h8000, rd)
        $display("test faults ended");
        // Broken load, full load with one parity failure, then one extra ignored write
        for (int i = 0; i < 8; i++)
            frame({10'h300, 6'($random(seed))}, 16);
        run_wr(6'h00);
        for (int i = 0; i < 17; i++) begin
            v = $random(seed);
            p = ~^v ^ (i == 5);
            frame({2'b11, 7'h00, p, v}, 16);
            if (i < 16) tab[i] = v;
            if (i == 6) `CHK("parity summary", 1'b1, rd[15])
        end
        for (int a = 0; a < 64; a++) begin
            run_wr(6'h01);
            `CHK("phase a", lvl_a(ang), phase_a_level)
            `CHK("phase b", lvl_b(ang), phase_b_level)
        end
        $display("test table ended");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
